// *** design/dsi_clk_pol.sv ***
// shift clock polarity select for the link domain
`timescale 1ns/1ps
`default_nettype none

module dsi_clk_pol (
  // pin clock
  input  wire logic i_shift_clk,
  // polarity select, 1 = rising edge active
  input  wire logic i_rise,
  // link clock, posedge is the active edge
  output logic      o_clk
);

  // ==========================================================
  // polarity
  // select moves only between frames, while the shift clock is idle
  assign o_clk = i_rise ? i_shift_clk : ~i_shift_clk;

endmodule

`default_nettype wire

// *** design/dsi_pkg.sv ***
// constants, types and the behaviour list of the dac serial input port
// Contract
// - after reset, serial_in is sampled on the falling shift clock edge
// - a control word switches sampling to the rising edge; host follows
// - bits gather in a 16-bit input register, one per active edge
// - shifting only on active edges while frame_select_n is low
// - rising frame_select_n moves the received word into the dac latch; code latches only full 16-bit words with ctrl not 3
// - chain_out changes on the edge opposite to the sampling edge
// - chain_out carries shifted-out bits so parts can be cascaded

package dsi_pkg;

  // ==========================================================
  // word layout
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CODE_W = 14;
  localparam int unsigned CTRL_W = 2;
  localparam int unsigned CNT_W  = 5;

  // control code that selects rising-edge sampling
  localparam logic [CTRL_W-1:0] CTRL_SET_RISE = 2'h3;

  // ==========================================================
  // values after reset and counts
  localparam logic [WORD_W-1:0] SREG_RST      = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RST      = 14'h0000;
  localparam logic              EDGE_RISE_RST = 1'h0;
  localparam logic              FRAME_N_RST   = 1'h1;
  localparam logic [CNT_W-1:0]  CNT_RST       = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE       = 5'h01;
  localparam logic [CNT_W-1:0]  CNT_FULL      = 5'h10;

  // ==========================================================
  // types
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [CODE_W-1:0] code;
  } dsi_word_t;

  // quasi-static view of the link side, read by the core at frame end
  typedef struct packed {
    dsi_word_t        word;
    logic [CNT_W-1:0] bits;
  } dsi_link_snap_t;

endpackage

// *** design/dsi_port.sv ***
// dac serial input port: shift register, chain output and dac latch
`timescale 1ns/1ps
`default_nettype none

module dsi_port (
  // core clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_srst,
  // serial link pins
  input  wire logic                       i_shift_clk,
  input  wire logic                       i_frame_select_n,
  input  wire logic                       i_serial_in,
  output logic                            o_chain_out,
  // dac latch
  output logic [dsi_pkg::CODE_W-1:0]      o_dac_code,
  output logic                            o_dac_load,
  // status
  output logic                            o_edge_rise,
  output logic                            o_word_err
);

  import dsi_pkg::*;

  // ==========================================================
  // link clock
  logic link_clk;

  dsi_clk_pol u_pol (
    .i_shift_clk (i_shift_clk),
    .i_rise      (o_edge_rise),
    .o_clk       (link_clk)
  );

  // ==========================================================
  // link domain
  // frame select and data are timed to the shift clock, so the link
  // logic reads them directly; the core side synchronises only frame select
  logic [WORD_W-1:0] sreg;
  logic [CNT_W-1:0]  bit_cnt;
  logic              armed;

  wire               shift_en;
  wire               arm_set;
  wire               cnt_sat;
  wire [WORD_W-1:0]  next_sreg;
  wire [CNT_W-1:0]   next_bit_cnt;

  assign shift_en     = ~i_frame_select_n;
  assign arm_set      = i_srst | i_frame_select_n;
  assign cnt_sat      = (bit_cnt == CNT_FULL);
  assign next_sreg    = {sreg[WORD_W-2:0], i_serial_in};
  assign next_bit_cnt = armed   ? CNT_ONE :
                        cnt_sat ? bit_cnt :
                                  bit_cnt + CNT_ONE;

  // posedge of link_clk is the active edge: falling pin edge by default
  always_ff @(posedge link_clk or posedge i_srst) begin
    if (i_srst) begin
      sreg <= SREG_RST;
    end else if (shift_en) begin
      sreg <= next_sreg;
    end
  end

  // bit count saturates at one word; a daisy chain only needs "full"
  always_ff @(posedge link_clk or posedge i_srst) begin
    if (i_srst) begin
      bit_cnt <= CNT_RST;
    end else if (shift_en) begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // armed while the frame is idle, so the first edge restarts the count
  always_ff @(posedge link_clk or posedge arm_set) begin
    if (arm_set) begin
      armed <= 1'h1;
    end else begin
      armed <= 1'h0;
    end
  end

  // opposite edge, so the next part sees the bit one active edge later
  always_ff @(negedge link_clk or posedge i_srst) begin
    if (i_srst) begin
      o_chain_out <= 1'h0;
    end else begin
      o_chain_out <= sreg[WORD_W-1];
    end
  end

  // ==========================================================
  // core domain: frame end detection
  logic           frame_n_s;
  logic           frame_n_d;
  dsi_link_snap_t snap;

  dsi_sync #(
    .W       (1),
    .RST_VAL (FRAME_N_RST)
  ) u_frame_sync (
    .i_clk  (i_core_clk),
    .i_srst (i_srst),
    .i_d    (i_frame_select_n),
    .o_q    (frame_n_s)
  );

  // the shift register is still while frame select is high; capture
  // lands about 30 ns after the rise, inside the least high time plus
  // setup, which limits how fast the next frame may start
  assign snap = {sreg, bit_cnt};

  wire frame_rise;
  wire word_ok;
  wire set_rise;
  wire do_load;
  wire do_edge;
  wire do_err;

  assign frame_rise = frame_n_s & ~frame_n_d;
  assign word_ok    = (snap.bits == CNT_FULL);
  assign set_rise   = (snap.word.ctrl == CTRL_SET_RISE);
  assign do_load    = frame_rise & word_ok & ~set_rise;
  assign do_edge    = frame_rise & word_ok & set_rise;
  assign do_err     = frame_rise & ~word_ok;

  // ==========================================================
  // core domain: dac latch and edge select
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      frame_n_d  <= FRAME_N_RST;
      o_dac_load <= 1'h0;
      o_word_err <= 1'h0;
    end else begin
      frame_n_d  <= frame_n_s;
      o_dac_load <= do_load;
      o_word_err <= do_err;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_dac_code <= CODE_RST;
    end else if (do_load) begin
      o_dac_code <= snap.word.code;
    end
  end

  // switching polarity may make one idle edge on link_clk; frame select
  // is high then, so nothing shifts; the idle edge is a posedge, so chain_out is not clocked
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_edge_rise <= EDGE_RISE_RST;
    end else if (do_edge) begin
      o_edge_rise <= 1'h1;
    end
  end

endmodule

`default_nettype wire

// *** design/dsi_sync.sv ***
// two-flop level synchroniser into the core clock domain
`timescale 1ns/1ps
`default_nettype none

module dsi_sync #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // level in and out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  // ==========================================================
  // synchroniser stages
  logic [W-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta <= RST_VAL;
      o_q  <= RST_VAL;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule

`default_nettype wire

// *** test/dsi_host.sv ***
// host model: drives the link pins and samples the chain output
`timescale 1ns/1ps
`default_nettype none
module dsi_host (
  // link pins
  output logic o_sclk,
  output logic o_fs_n,
  output logic o_sd,
  // chain output
  input wire logic i_co
);
  logic got [64];
  logic aft [64];
  initial begin
    o_sclk = 1'b1; // clock stands high between frames
    o_fs_n = 1'b1;
    o_sd = 1'b0;
  end
  // sel low keeps select high: every edge then ought to be ignored
  task automatic frame(input logic [63:0] w, input int n, input bit rise,
                       input bit sel);
    o_fs_n = !sel;
    for (int i = 0; i < n; i++) begin
      if (!rise) o_sd = w[n-1-i];
      #80;
      if (!rise) got[i] = i_co;
      else if (i > 0) aft[i-1] = i_co; // after the rising active edge
      o_sclk = 1'b0;
      if (rise) o_sd = w[n-1-i];
      #20 if (!rise) aft[i] = i_co;
      #60 if (rise) got[i] = i_co;
      o_sclk = 1'b1;
    end
    #80;
    if (rise) aft[n-1] = i_co;
    o_fs_n = 1'b1;
    o_sd = !o_sd; // released line must not look still driven
  endtask
endmodule
`default_nettype wire

// *** test/dsi_port_sva.sv ***
// port checker of the dac serial input port
`timescale 1ns/1ps
`default_nettype none
module dsi_port_sva (
  // clock, reset and pins
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_shift_clk,
  input wire logic i_frame_select_n,
  input wire logic i_serial_in,
  // outputs
  input wire logic o_chain_out,
  input wire logic [dsi_pkg::CODE_W-1:0] o_dac_code,
  input wire logic o_dac_load,
  input wire logic o_edge_rise,
  input wire logic o_word_err
);
  import dsi_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // ==========================================
  // frame end events
  a_code_hold: assert property (!o_dac_load |-> $stable(o_dac_code))
    else $error("code moved");
  a_load_pulse: assert property (o_dac_load |=> !o_dac_load)
    else $error("load too long");
  a_err_pulse: assert property (o_word_err |=> !o_word_err)
    else $error("error too long");
  a_one_event: assert property (!(o_dac_load && o_word_err))
    else $error("load with error");
  a_load_cause: assert property (o_dac_load |->
    $past(i_frame_select_n) && $past(i_frame_select_n, 2))
    else $error("load inside frame");
  a_rise_answer: assert property ($rose(i_frame_select_n) |->
    ##[1:4] (o_dac_load || o_word_err || $rose(o_edge_rise)))
    else $error("frame end lost");
  a_edge_sticky: assert property (o_edge_rise |=> o_edge_rise)
    else $error("edge fell back");
  a_edge_no_load: assert property ($rose(o_edge_rise) |-> !o_dac_load)
    else $error("edge with load");
endmodule
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench of the dac serial input port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsi_pkg::*;
  logic i_core_clk, i_srst, i_shift_clk, i_frame_select_n, i_serial_in;
  logic o_chain_out, o_dac_load, o_edge_rise, o_word_err, ld, er, setr;
  logic [CODE_W-1:0] o_dac_code;
  int num_errors, total_checks, sreg, code, edge_r, t;
  dsi_port i_dsi_port (.i_core_clk, .i_srst, .i_shift_clk, .i_frame_select_n,
    .i_serial_in, .o_chain_out, .o_dac_code, .o_dac_load, .o_edge_rise,
    .o_word_err);
  dsi_host i_dsi_host (.o_sclk(i_shift_clk), .o_fs_n(i_frame_select_n),
    .o_sd(i_serial_in), .i_co(o_chain_out));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one frame; the model shifts alongside, then the frame end is judged
  task automatic run(input logic [63:0] w, input int n, input bit sel);
    @(negedge i_core_clk) #3;
    i_dsi_host.frame(w, n, edge_r[0], sel);
    for (int i = 0; i < n && sel; i++) begin
      check(i_dsi_host.got[i], sreg[15]);
      check(i_dsi_host.aft[i], sreg[15]);
      sreg = ((sreg << 1) | w[n-1-i]) & 16'hffff;
    end
    for (t = 0; t < 20; t++) begin
      @(posedge i_core_clk) #1;
      if (o_dac_load || o_word_err || o_edge_rise != edge_r[0]) break;
    end
    if (sel && t == 20) begin
      num_errors++;
      end_of_test();
    end
    setr = sel && n >= 16 && sreg[15:14] == CTRL_SET_RISE;
    ld = sel && n >= 16 && !setr;
    er = sel && n < 16;
    check({o_dac_load, o_word_err, o_edge_rise},
          {ld, er, edge_r[0] | setr});
    if (ld) code = sreg & 16'h3fff;
    edge_r = edge_r | setr;
    check(o_dac_code, code[13:0]);
  endtask
  initial begin
    i_srst = 1'b1;
    sreg = 0;
    code = 0;
    edge_r = 0;
    void'($urandom(24));
    repeat (20) @(posedge i_core_clk);
    @(negedge i_core_clk) i_srst = 1'b0;
    check(o_edge_rise, 1'b0);
    check(o_dac_code, CODE_RST);
    repeat (4) @(negedge i_core_clk);
    for (int k = 0; k < 4; k++) run($urandom % 16'hc000, 16, 1'b1);
    run({$urandom, 16'($urandom % 16'hc000)}, 48, 1'b1);
    run(64'h0000_0000_0000_0055, 7, 1'b1);
    run(64'h0000_0000_0000_1234, 16, 1'b0);
    run(64'h0000_0000_0000_c123, 16, 1'b1);
    for (int k = 0; k < 4; k++) run($urandom % 16'hc000, 16, 1'b1);
    // mid-run reset: only reset brings back falling-edge sampling
    @(negedge i_core_clk) i_srst = 1'b1;
    repeat (20) @(negedge i_core_clk);
    i_srst = 1'b0;
    sreg = 0;
    code = 0;
    edge_r = 0;
    check(o_edge_rise, 1'b0);
    check(o_dac_code, CODE_RST);
    repeat (4) @(negedge i_core_clk);
    for (int k = 0; k < 2; k++) run($urandom % 16'hc000, 16, 1'b1);
    end_of_test();
  end
endmodule
bind dsi_port dsi_port_sva i_dsi_port_sva (.i_core_clk, .i_srst, .i_shift_clk,
  .i_frame_select_n, .i_serial_in, .o_chain_out, .o_dac_code, .o_dac_load,
  .o_edge_rise, .o_word_err);
`default_nettype wire
